// ### design/mbp_pkg.sv
// Purpose: Shared constants for the multiplexed bus port and power-on output.
// Assumes: 8-bit shared address/data bus, 250 MHz ref_clk.
// Notes:   Register contents other than control register 4B live in a plain array.
package mbp_pkg;
    localparam int          MBP_DATA_W       = 8;
    localparam int          MBP_ADDR_W       = 8;
    localparam int          MBP_MEM_DEPTH    = 256;
    // Extended control register holding crystal select and wake controls.
    localparam logic [7:0]  MBP_ADDR_CTRL_4B = 8'h4B;
    localparam int          MBP_BIT_XSEL     = 0;
    localparam int          MBP_BIT_WKEN     = 1;
    localparam int          MBP_BIT_ABEN     = 2;
    localparam int          MBP_BIT_PWRON    = 3;
    localparam logic [7:0]  MBP_CTRL_RST     = 8'h00;
    localparam logic [7:0]  MBP_BYTE_RST     = 8'h00;
    localparam logic [1:0]  MBP_SYNC_RST     = 2'h3;
endpackage : mbp_pkg

// ### design/mbp_sync.sv
// Purpose: Two-flop synchroniser for one asynchronous pin.
// Assumes: Pin idles at the reset level given by RST_VAL.
// Notes:   Only the second flop is visible outside.
`timescale 1ns/1ps
`default_nettype none
module mbp_sync #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Pin in, synchronised level out.
    input  wire logic pin_in,
    output logic      sync_out
);
    logic meta_r;
    logic meta_nxt;
    logic sync_r;
    logic sync_nxt;

    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule : mbp_sync
`default_nettype wire

// ### design/mbp_port.sv
// Purpose: Device end of a multiplexed address/data host port with power-on output.
// Assumes: All host pins are asynchronous and pass two flops before use.
// Notes:   Strobes are sampled, so host pulses must span several ref_clk cycles.
// Summary of operation
// - Bus lines carry address first, then data, on the same pins.
// - Address is captured at the falling edge of the latch strobe.
// - A read drives the addressed byte onto the bus late in the read strobe.
// - Read ends and drivers float when the read strobe returns high.
// - Latch strobe without chip select latches address but moves no data.
// - Bus data is written to the latched location only during the write strobe.
// - Output drivers are enabled only while the read strobe is low.
// - The same protocol reaches the extended battery-backed RAM.
// - Without main power, wake key or wake alarm asserts the power-on output.
// - With power present, a software control bit sets the power-on output.
// - Crystal-select control bit in register 4B picks 6pF or 12.5pF load.
// - Wake key path works only when both battery and key enables are 1.
`timescale 1ns/1ps
`default_nettype none
module mbp_port (
    // Clock and reset.
    input  wire logic                           ref_clk,
    input  wire logic                           rst_n,
    // Shared bus lines, split into input, output and output enable (low drives).
    input  wire logic [mbp_pkg::MBP_DATA_W-1:0] shared_bus_lines_in,
    output logic      [mbp_pkg::MBP_DATA_W-1:0] shared_bus_lines_out,
    output logic                                shared_bus_lines_oe_n,
    // Host strobes.
    input  wire logic                           addr_latch,
    input  wire logic                           chip_sel_n,
    input  wire logic                           rd_n,
    input  wire logic                           wr_n,
    // Power control.
    input  wire logic                           main_power_ok,
    input  wire logic                           wake_key_n,
    input  wire logic                           wake_alarm,
    output logic                                power_on_request_n_out,
    output logic                                power_on_request_n_oe_n,
    // Oscillator load select, high for 12.5pF, low for 6pF.
    output logic                                xtal_load_sel
);
    import mbp_pkg::*;

    // Synchronised copies of the host and power pins.
    logic                  ale_s;
    logic                  cs_n_s;
    logic                  rd_n_s;
    logic                  wr_n_s;
    logic                  pwr_s;
    logic                  key_n_s;
    logic                  alarm_s;
    logic [MBP_DATA_W-1:0] bus_s;

    // Battery-backed byte store; the control register is kept apart from it.
    logic [MBP_DATA_W-1:0] mem [MBP_MEM_DEPTH];

    // Edge detector history.
    logic                  ale_d_r;
    logic                  ale_d_nxt;
    logic                  key_d_r;
    logic                  key_d_nxt;
    // Address latch.
    logic [MBP_ADDR_W-1:0] addr_r;
    logic [MBP_ADDR_W-1:0] addr_nxt;
    // Control register and crystal select.
    logic [MBP_DATA_W-1:0] ctrl_r;
    logic [MBP_DATA_W-1:0] ctrl_nxt;
    logic                  xsel_r;
    logic                  xsel_nxt;
    // Read path.
    logic [MBP_DATA_W-1:0] rdata_r;
    logic [MBP_DATA_W-1:0] rdata_nxt;
    logic                  oe_n_r;
    logic                  oe_n_nxt;
    // Power-on request.
    logic                  pwr_req_r;
    logic                  pwr_req_nxt;
    // Decoded strobes and edges.
    logic                  wr_active;
    logic                  rd_active;
    logic                  ale_fall;
    logic                  key_fall;
    logic                  ctrl_hit;
    logic                  key_armed;

    // Every host pin is asynchronous, so each passes two flops before use.
    // Bus and strobes share the same lag, which keeps data aligned with strobes.
    mbp_sync #(.RST_VAL(1'b0)) u_ale (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(addr_latch), .sync_out(ale_s));
    mbp_sync #(.RST_VAL(1'b1)) u_cs (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(chip_sel_n), .sync_out(cs_n_s));
    mbp_sync #(.RST_VAL(1'b1)) u_rd (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(rd_n), .sync_out(rd_n_s));
    mbp_sync #(.RST_VAL(1'b1)) u_wr (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(wr_n), .sync_out(wr_n_s));
    mbp_sync #(.RST_VAL(1'b0)) u_pwr (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(main_power_ok), .sync_out(pwr_s));
    mbp_sync #(.RST_VAL(1'b1)) u_key (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(wake_key_n), .sync_out(key_n_s));
    mbp_sync #(.RST_VAL(1'b0)) u_alm (.ref_clk(ref_clk), .rst_n(rst_n),
        .pin_in(wake_alarm), .sync_out(alarm_s));

    for (genvar i = 0; i < MBP_DATA_W; i++) begin : g_bus_sync
        mbp_sync #(.RST_VAL(1'b0)) u_bit (.ref_clk(ref_clk), .rst_n(rst_n),
            .pin_in(shared_bus_lines_in[i]), .sync_out(bus_s[i]));
    end

    // Data moves only with chip select low, so a stray latch strobe is harmless.
    assign wr_active = !wr_n_s && !cs_n_s;
    assign rd_active = !rd_n_s && !cs_n_s;
    assign ale_fall  = ale_d_r && !ale_s;
    assign key_fall  = key_d_r && !key_n_s;
    assign ctrl_hit  = (addr_r == MBP_ADDR_CTRL_4B);
    // The key only counts when both battery and key enables are set.
    assign key_armed = ctrl_r[MBP_BIT_ABEN] && ctrl_r[MBP_BIT_WKEN];

    always_comb begin
        ale_d_nxt = ale_s;
        key_d_nxt = key_n_s;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Both start at the idle level of their pins, so reset makes no edge.
            ale_d_r <= 1'b0;
            key_d_r <= 1'b1;
        end else begin
            ale_d_r <= ale_d_nxt;
            key_d_r <= key_d_nxt;
        end
    end

    // The address holds until the next latch strobe falls, so one address
    // phase may serve any number of data phases that follow it.
    always_comb begin
        addr_nxt = addr_r;
        if (ale_fall) begin
            addr_nxt = bus_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_r <= MBP_BYTE_RST;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        // Every write cycle stores, so the last sample before the strobe rises wins.
        if (wr_active && ctrl_hit) begin
            ctrl_nxt = bus_s;
        end
        xsel_nxt = ctrl_r[MBP_BIT_XSEL];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= MBP_CTRL_RST;
            xsel_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            xsel_r <= xsel_nxt;
        end
    end

    // The store has no reset, as battery-backed contents survive a system reset.
    always_ff @(posedge ref_clk) begin
        if (wr_active && !ctrl_hit) begin
            mem[addr_r] <= bus_s;
        end
    end

    always_comb begin
        rdata_nxt = mem[addr_r];
        if (ctrl_hit) begin
            rdata_nxt = ctrl_r;
        end
        // Drivers follow the read strobe both ways, so the bus floats as it rises.
        oe_n_nxt = !rd_active;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_r <= MBP_BYTE_RST;
            oe_n_r  <= 1'b1;
        end else begin
            rdata_r <= rdata_nxt;
            oe_n_r  <= oe_n_nxt;
        end
    end

    // With mains present software owns the request. Without mains the request
    // is sticky: the alarm or an armed key edge sets it, and once power has
    // returned it follows the software control bit again.
    always_comb begin
        pwr_req_nxt = pwr_req_r;
        if (pwr_s) begin
            pwr_req_nxt = ctrl_r[MBP_BIT_PWRON];
        end else if (alarm_s) begin
            pwr_req_nxt = 1'b1;
        end else if (key_fall && key_armed) begin
            pwr_req_nxt = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwr_req_r <= 1'b0;
        end else begin
            pwr_req_r <= pwr_req_nxt;
        end
    end

    assign shared_bus_lines_out    = rdata_r;
    assign shared_bus_lines_oe_n   = oe_n_r;
    // Open drain: pin data is always low, enable is low while pulling.
    assign power_on_request_n_out  = 1'b0;
    assign power_on_request_n_oe_n = !pwr_req_r;
    assign xtal_load_sel           = xsel_r;
endmodule : mbp_port
`default_nettype wire

// ### tb/mbp_port_properties.sv
// Purpose: Pin checks for mbp_port.
// Assumes: Host strobes last four cycles or more.
// Notes:   A pin reaches an output three edges late: two sync flops and one register; four edges via ctrl_r.
`timescale 1ns/1ps
`default_nettype none
module mbp_port_chk (
    // Clock, reset and bus.
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [7:0] shared_bus_lines_out,
    input wire logic       shared_bus_lines_oe_n,
    input wire logic       chip_sel_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    // Power and crystal.
    input wire logic       main_power_ok,
    input wire logic       wake_key_n,
    input wire logic       wake_alarm,
    input wire logic       power_on_request_n_oe_n,
    input wire logic       xtal_load_sel
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rd; !shared_bus_lines_oe_n |-> !$past(rd_n, 3) && !$past(chip_sel_n, 3);
    endproperty
    a_rd: assert property (p_rd) else $error("drive without read");
    property p_fl; rd_n [*5] |-> shared_bus_lines_oe_n; endproperty
    a_fl: assert property (p_fl) else $error("bus not floated");
    property p_cs; chip_sel_n [*5] |-> shared_bus_lines_oe_n; endproperty
    a_cs: assert property (p_cs) else $error("drive without select");
    property p_hd; (wr_n && !shared_bus_lines_oe_n) [*4] |-> $stable(shared_bus_lines_out);
    endproperty
    a_hd: assert property (p_hd) else $error("read byte moved");
    property p_wk; $fell(power_on_request_n_oe_n) && !$past(main_power_ok, 3)
        |-> $past(wake_alarm, 3) || (!$past(wake_key_n, 3) && $past(wake_key_n, 4));
    endproperty
    a_wk: assert property (p_wk) else $error("power on without wake");
    property p_st; (!main_power_ok) [*5] ##0 !power_on_request_n_oe_n
        |=> !power_on_request_n_oe_n; endproperty
    a_st: assert property (p_st) else $error("power on dropped");
    property p_pw; main_power_ok [*5] ##0 $fell(power_on_request_n_oe_n)
        |-> !$past(wr_n, 4) && !$past(chip_sel_n, 4); endproperty
    a_pw: assert property (p_pw) else $error("power on without write");
    property p_xt; $changed(xtal_load_sel) |-> !$past(wr_n, 4) && !$past(chip_sel_n, 4);
    endproperty
    a_xt: assert property (p_xt) else $error("crystal select moved");
endmodule : mbp_port_chk
bind mbp_port mbp_port_chk i_chk (
    .ref_clk                 (ref_clk),
    .rst_n                   (rst_n),
    .shared_bus_lines_out    (shared_bus_lines_out),
    .shared_bus_lines_oe_n   (shared_bus_lines_oe_n),
    .chip_sel_n              (chip_sel_n),
    .rd_n                    (rd_n),
    .wr_n                    (wr_n),
    .main_power_ok           (main_power_ok),
    .wake_key_n              (wake_key_n),
    .wake_alarm              (wake_alarm),
    .power_on_request_n_oe_n (power_on_request_n_oe_n),
    .xtal_load_sel           (xtal_load_sel)
);
`default_nettype wire

// ### tb/mbp_host.sv
// Purpose: Host processor model for the port pins.
// Assumes: Calls start and end on a falling edge.
// Notes:   An undriven bus shows a moving pattern.
`timescale 1ns/1ps
`default_nettype none
module mbp_host (
    // Device side.
    input  wire logic       ref_clk,
    input  wire logic [7:0] shared_bus_lines_out,
    input  wire logic       shared_bus_lines_oe_n,
    // Host pins.
    output logic      [7:0] shared_bus_lines_in,
    output logic            addr_latch,
    output logic            chip_sel_n,
    output logic            rd_n,
    output logic            wr_n
);
    logic [7:0] hval;
    logic [7:0] idle = 8'h00;
    logic       hdrv;
    initial {addr_latch, hdrv, chip_sel_n, rd_n, wr_n} = 5'h07;
    always @(posedge ref_clk) idle <= idle + 8'h35;
    assign shared_bus_lines_in = !shared_bus_lines_oe_n ? shared_bus_lines_out
                               : hdrv ? hval : idle;
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    // Address stays four cycles past the strobe fall to cover the input lag.
    task automatic latch(input logic [7:0] a);
        {hdrv, hval, addr_latch} = {1'b1, a, 1'b1};
        tick(4);
        addr_latch = 1'b0;
        tick(4);
    endtask : latch
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic cs_n);
        latch(a);
        {hval, chip_sel_n, wr_n} = {d, cs_n, 1'b0};
        tick(5);
        wr_n = 1'b1;
        tick(1);
        {hdrv, chip_sel_n} = 2'h1;
        tick(1);
    endtask : wr
    // Data phase only: reads whatever address the device holds latched now.
    task automatic rd_cyc(output logic [7:0] d);
        {hdrv, chip_sel_n, rd_n} = 3'h0;
        for (int n = 0; n < 9 && shared_bus_lines_oe_n !== 1'b0; n++) tick(1);
        tick(4);
        d = shared_bus_lines_in;
        {chip_sel_n, rd_n} = 2'h3;
        tick(4);
    endtask : rd_cyc
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        latch(a);
        rd_cyc(d);
    endtask : rd
endmodule : mbp_host
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for mbp_port.
// Assumes: mbp_host makes every bus cycle.
// Notes:   The byte model holds only written places.
`timescale 1ns/1ps
`default_nettype none
module tb;
    wire  [7:0] shared_bus_lines_in, shared_bus_lines_out;
    wire        shared_bus_lines_oe_n, addr_latch, chip_sel_n, rd_n, wr_n;
    wire        power_on_request_n_out, power_on_request_n_oe_n, xtal_load_sel;
    logic       ref_clk = 1'b0, rst_n = 1'b0, main_power_ok = 1'b1;
    logic       wake_key_n = 1'b1, wake_alarm = 1'b0;
    logic [7:0] m [int];
    logic [7:0] d;
    int         failures = 0, comparisons = 0, seed = 69, cyc = 0, a = 0;
    mbp_port i_mbp_port (
        .ref_clk                 (ref_clk),
        .rst_n                   (rst_n),
        .shared_bus_lines_in     (shared_bus_lines_in),
        .shared_bus_lines_out    (shared_bus_lines_out),
        .shared_bus_lines_oe_n   (shared_bus_lines_oe_n),
        .addr_latch              (addr_latch),
        .chip_sel_n              (chip_sel_n),
        .rd_n                    (rd_n),
        .wr_n                    (wr_n),
        .main_power_ok           (main_power_ok),
        .wake_key_n              (wake_key_n),
        .wake_alarm              (wake_alarm),
        .power_on_request_n_out  (power_on_request_n_out),
        .power_on_request_n_oe_n (power_on_request_n_oe_n),
        .xtal_load_sel           (xtal_load_sel)
    );
    mbp_host i_mbp_host (
        .ref_clk                 (ref_clk),
        .shared_bus_lines_out    (shared_bus_lines_out),
        .shared_bus_lines_oe_n   (shared_bus_lines_oe_n),
        .shared_bus_lines_in     (shared_bus_lines_in),
        .addr_latch              (addr_latch),
        .chip_sel_n              (chip_sel_n),
        .rd_n                    (rd_n),
        .wr_n                    (wr_n)
    );
    initial forever #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic tally(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask : tally
    task automatic chk_rd(input string nm, input logic [7:0] e, input logic [7:0] g);
        tally(nm, e, g);
    endtask : chk_rd
    task automatic chk_xt(input logic e, input logic g);
        tally("xtal", {7'h0, e}, {7'h0, g});
    endtask : chk_xt
    task automatic chk_pw(input string nm, input logic e, input logic g);
        tally(nm, {7'h0, e}, {7'h0, g});
    endtask : chk_pw
    task automatic hw(input int k, input logic [7:0] v, input logic cs_n);
        i_mbp_host.wr(k[7:0], v, cs_n);
        if (!cs_n) m[k] = v;
    endtask : hw
    task automatic hr(input int k);
        i_mbp_host.rd(k[7:0], d);
        chk_rd("read", m[k], d);
    endtask : hr
    task automatic pw(input logic e);
        i_mbp_host.tick(6);
        chk_pw("power", e, power_on_request_n_oe_n);
        chk_pw("power pin", 1'b0, power_on_request_n_out);
    endtask : pw
    task automatic print_verdict();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    initial begin
        i_mbp_host.tick(2);
        rst_n = 1'b1;
        i_mbp_host.tick(4);
        chk_xt(1'b0, xtal_load_sel);
        hw(8'h10, 8'hC3, 1'b0);
        repeat (8) begin
            a = 8'h80 | ($random(seed) & 8'h7F);
            hw(a, 8'($random(seed)), 1'b0);
        end
        foreach (m[k]) hr(k);
        hr(8'h10);
        hw(a, 8'h5A, 1'b1);
        i_mbp_host.rd_cyc(d);
        chk_rd("held address", m[a], d);
        hr(a);
        hw(8'h4B, 8'h09, 1'b0);
        chk_xt(1'b1, xtal_load_sel);
        pw(1'b0);
        hw(8'h4B, 8'h02, 1'b0);
        pw(1'b1);
        main_power_ok = 1'b0;
        wake_key_n = 1'b0;
        pw(1'b1);
        wake_key_n = 1'b1;
        hw(8'h4B, 8'h06, 1'b0);
        wake_key_n = 1'b0;
        pw(1'b0);
        wake_key_n = 1'b1;
        main_power_ok = 1'b1;
        pw(1'b1);
        main_power_ok = 1'b0;
        wake_alarm = 1'b1;
        pw(1'b0);
        wake_alarm = 1'b0;
        hr(8'h4B);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
